// ---- dpram_ctl_pkg.sv ----
// package: constants for the dual-port ram port controller
package dpram_ctl_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;
  localparam int FLAG_SEL_W = 3;
  // command encodings on the user port
  localparam logic [1:0] CMD_MEM_WRITE = 2'h0;
  localparam logic [1:0] CMD_MEM_READ = 2'h1;
  localparam logic [1:0] CMD_FLAG_WRITE = 2'h2;
  localparam logic [1:0] CMD_FLAG_READ = 2'h3;
  // byte enable field positions
  localparam int BE_LOWER = 0;
  localparam int BE_UPPER = 1;
  // timing: setup and strobe times in ns at 100 ns clock
  localparam int CLK_NS = 100;
  localparam int SETUP_NS = 100;
  localparam int STROBE_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  typedef enum {DPC_IDLE, DPC_SETUP, DPC_STROBE, DPC_RELEASE} dpc_state_e;
endpackage

// ---- dpram_ctl.sv ----
// host-side controller that drives one port of the dual-port ram
// Function
// - Upper-only write: select low, write low, upper low, lower high, flag high.
// - Lower-only write: select low, write low, lower low, upper high, flag high.
// - Flag read: flag low, write high, oe low, select high; all lines data.
// - Flag write on rising write strobe with flag low and select high.
`timescale 1ns/1ps
module dpram_ctl
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // user command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [1:0] cmd_byte_en,
  input wire logic [dpram_ctl_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [dpram_ctl_pkg::DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [dpram_ctl_pkg::DATA_W-1:0] rsp_rdata,
  // ram port pins
  output logic port_select_n,
  output logic write_strobe_n,
  output logic output_drive_enable_n,
  output logic upper_byte_select_n,
  output logic lower_byte_select_n,
  output logic flag_space_select_n,
  output logic [dpram_ctl_pkg::ADDR_W-1:0] ram_addr,
  input wire logic [dpram_ctl_pkg::DATA_W-1:0] ram_data_in,
  output logic [dpram_ctl_pkg::DATA_W-1:0] ram_data_out,
  output logic ram_data_oe_n
);
  import dpram_ctl_pkg::*;

  dpc_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [1:0] op_reg;
  logic [DATA_W-1:0] din_meta_reg;
  logic [DATA_W-1:0] din_sync_reg;
  logic cmd_take;

  // true when the command is a write of either kind
  function automatic logic is_write(input logic [1:0] op);
    is_write = (op == CMD_MEM_WRITE) || (op == CMD_FLAG_WRITE);
  endfunction

  // true when the command targets the flag space
  function automatic logic is_flag(input logic [1:0] op);
    is_flag = (op == CMD_FLAG_WRITE) || (op == CMD_FLAG_READ);
  endfunction

  // two-stage synchroniser on the data pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end else begin
      din_meta_reg <= ram_data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  // access sequencer: setup, strobe, release with a read capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= DPC_IDLE;
      cnt_reg <= 4'h0;
      op_reg <= CMD_MEM_READ;
    end else begin
      case (state_reg)
        DPC_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            op_reg <= cmd_op;
            cnt_reg <= SETUP_CNT;
            state_reg <= DPC_SETUP;
          end
        end
        DPC_SETUP: begin
          if (cnt_reg <= 4'h1) begin
            cnt_reg <= STROBE_CNT + 4'h2; // two extra for the read synchroniser
            state_reg <= DPC_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        DPC_STROBE: begin
          if (cnt_reg <= 4'h1) begin
            state_reg <= DPC_RELEASE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        DPC_RELEASE: begin
          state_reg <= DPC_IDLE;
        end
        default: begin
          state_reg <= DPC_IDLE;
        end
      endcase
    end
  end

  // a command is taken only at an edge where the controller shows ready
  assign cmd_take = cmd_valid && cmd_ready;

  // port and byte selects; flag accesses keep port select high so cannot occur
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_select_n <= 1'b1;
      upper_byte_select_n <= 1'b1;
      lower_byte_select_n <= 1'b1;
    end else if (cmd_take) begin
      if (is_flag(cmd_op)) begin
        port_select_n <= 1'b1;
        upper_byte_select_n <= 1'b1;
        lower_byte_select_n <= 1'b1;
      end else begin
        port_select_n <= 1'b0;
        upper_byte_select_n <= ~cmd_byte_en[BE_UPPER];
        lower_byte_select_n <= ~cmd_byte_en[BE_LOWER];
      end
    end else if (state_reg == DPC_RELEASE) begin
      // deselect only after the strobe has risen, so the write completes
      port_select_n <= 1'b1;
      upper_byte_select_n <= 1'b1;
      lower_byte_select_n <= 1'b1;
    end
  end

  // flag space select stands for the whole flag access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_space_select_n <= 1'b1;
    end else if (cmd_take) begin
      flag_space_select_n <= ~is_flag(cmd_op);
    end else if (state_reg == DPC_RELEASE) begin
      flag_space_select_n <= 1'b1;
    end
  end

  // write strobe low for the strobe phase of a write; its rising edge stores the data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_strobe_n <= 1'b1;
    end else if (state_reg == DPC_SETUP && cnt_reg <= 4'h1) begin
      write_strobe_n <= ~is_write(op_reg);
    end else if (state_reg == DPC_STROBE && cnt_reg <= 4'h1) begin
      write_strobe_n <= 1'b1;
    end
  end

  // output enable low for reads only, so the ram never drives against the host
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      output_drive_enable_n <= 1'b1;
    end else if (cmd_take) begin
      output_drive_enable_n <= is_write(cmd_op);
    end else if (state_reg == DPC_RELEASE) begin
      output_drive_enable_n <= 1'b1;
    end
  end

  // address stands from the take until the next command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_addr <= '0;
    end else if (cmd_take) begin
      ram_addr <= cmd_addr;
    end
  end

  // write data: a flag write carries its value on bit zero, the rest low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_data_out <= '0;
    end else if (cmd_take) begin
      if (is_flag(cmd_op)) begin
        ram_data_out <= {{(DATA_W-1){1'b0}}, cmd_wdata[0]};
      end else begin
        ram_data_out <= cmd_wdata;
      end
    end
  end

  // host drives the data lines only for writes; released with the selects
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_data_oe_n <= 1'b1;
    end else if (cmd_take) begin
      ram_data_oe_n <= ~is_write(cmd_op);
    end else if (state_reg == DPC_RELEASE) begin
      ram_data_oe_n <= 1'b1;
    end
  end

  // ready only while idle and not taking a command at this edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= (state_reg == DPC_IDLE) && !cmd_take;
    end
  end

  // one-cycle answer at the end of the strobe; reads use the synchronised pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_reg == DPC_STROBE && cnt_reg <= 4'h1) begin
        rsp_valid <= 1'b1;
        if (is_write(op_reg)) begin
          rsp_rdata <= '0;
        end else if (is_flag(op_reg)) begin
          rsp_rdata <= {DATA_W{din_sync_reg[0]}};
        end else begin
          rsp_rdata <= din_sync_reg;
        end
      end
    end
  end
endmodule

// ---- dpram_ctl_asserts.sv ----
// checker: pin-level assertions for the dual-port ram controller
`timescale 1ns/1ps
module dpram_ctl_asserts (
  // clock, reset, handshake
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  // ram pins
  input wire logic port_select_n,
  input wire logic write_strobe_n,
  input wire logic output_drive_enable_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  input wire logic flag_space_select_n,
  input wire logic ram_data_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_flag; !flag_space_select_n; endsequence
  sequence s_strobe; !write_strobe_n [*3] ##1 write_strobe_n; endsequence
  // flag space only with the memory side off: port select high or both byte selects high
  AST_FLAG_SAFE: assert property (s_flag |-> port_select_n ||
    (upper_byte_select_n && lower_byte_select_n)) else $error("bad flag select");
  AST_MEM_WRITE: assert property (!write_strobe_n && flag_space_select_n |->
    !port_select_n && !ram_data_oe_n) else $error("bad memory write");
  AST_FLAG_WRITE: assert property ($rose(write_strobe_n) && !flag_space_select_n |->
    !ram_data_oe_n)
    else $error("flag write undriven");
  AST_READ_FLOAT: assert property (write_strobe_n && !output_drive_enable_n |-> ram_data_oe_n)
    else $error("host drives during read");
  AST_STROBE: assert property ($fell(write_strobe_n) |-> s_strobe)
    else $error("bad strobe length");
  AST_ANSWER: assert property (cmd_valid && cmd_ready |-> ##5 rsp_valid)
    else $error("late answer");
endmodule
bind dpram_ctl dpram_ctl_asserts u_dpram_ctl_asserts (.clk(clk), .reset_n(reset_n),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .port_select_n(port_select_n), .write_strobe_n(write_strobe_n),
  .output_drive_enable_n(output_drive_enable_n), .upper_byte_select_n(upper_byte_select_n),
  .lower_byte_select_n(lower_byte_select_n), .flag_space_select_n(flag_space_select_n),
  .ram_data_oe_n(ram_data_oe_n));

// ---- dpram_model.sv ----
// partner model: one ram port with its eight shared flags
`timescale 1ns/1ps
module dpram_model (
  // pins
  input wire logic clk,
  input wire logic ps_n,
  input wire logic ws_n,
  input wire logic oe_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  input wire logic fs_n,
  input wire logic [12:0] a,
  input wire logic [15:0] d,
  output logic [15:0] q
);
  logic [15:0] mem [0:8191];
  logic [7:0] flag = 8'hff;
  logic [15:0] pat = 16'h5a5a;
  logic fsel;
  assign fsel = !fs_n && (ps_n || (upper_byte_select_n && lower_byte_select_n));
  // floating lines show a pattern that flips every cycle
  always @(posedge clk) pat <= ~pat;
  // writes land on the rising strobe
  always @(posedge ws_n) begin
    if (fsel) flag[a[2:0]] <= d[0];
    else if (!ps_n && fs_n) begin
      if (!upper_byte_select_n) mem[a][15:8] <= d[15:8];
      if (!lower_byte_select_n) mem[a][7:0] <= d[7:0];
    end
  end
  // memory reads drive only the selected halves; flag reads drive all lines
  always_comb begin
    q = pat;
    if (ws_n && !oe_n && fsel) q = {16{flag[a[2:0]]}};
    else if (ws_n && !oe_n && !ps_n && fs_n) begin
      if (!upper_byte_select_n) q[15:8] = mem[a][15:8];
      if (!lower_byte_select_n) q[7:0] = mem[a][7:0];
    end
  end
endmodule

// ---- tb_dpram_ctl.sv ----
// testbench: random memory traffic and flag accesses through the controller
`timescale 1ns/1ps
module tb_dpram_ctl;
  import dpram_ctl_pkg::*;
  logic clk = 1'h0, reset_n = 1'h0, cmd_valid = 1'h0, cmd_ready, rsp_valid, ps_n, ws_n, oe_n;
  logic upper_byte_select_n, lower_byte_select_n, fs_n, doe_n;
  logic [7:0] fv;
  logic [1:0] cmd_op = 2'h0, cmd_byte_en = 2'h0, be;
  logic [12:0] cmd_addr = 13'h0, ram_addr, a;
  logic [15:0] cmd_wdata = 16'h0, rsp_rdata, din, dout, rd, w, ew;
  int err_count = 0, checked = 0, cyc = 0;
  dpram_ctl u_dpram_ctl (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_byte_en(cmd_byte_en), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .port_select_n(ps_n),
    .write_strobe_n(ws_n), .output_drive_enable_n(oe_n),
    .upper_byte_select_n(upper_byte_select_n),
    .lower_byte_select_n(lower_byte_select_n), .flag_space_select_n(fs_n), .ram_addr(ram_addr),
    .ram_data_in(din), .ram_data_out(dout), .ram_data_oe_n(doe_n));
  dpram_model u_dpram_model (.clk(clk), .ps_n(ps_n), .ws_n(ws_n), .oe_n(oe_n),
    .upper_byte_select_n(upper_byte_select_n), .lower_byte_select_n(lower_byte_select_n),
    .fs_n(fs_n), .a(ram_addr), .d(dout), .q(din));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [15:0] bmask(input logic [1:0] m);
    return {{8{m[1]}}, {8{m[0]}}};
  endfunction
  // one command: wait ready, hold valid one edge, catch the answer
  task automatic cmd(input logic [1:0] op, input logic [1:0] m, input logic [12:0] x,
    input logic [15:0] v);
    repeat (20) if (cmd_ready !== 1'h1) @(negedge clk);
    if (cmd_ready !== 1'h1) begin
      err_count++;
      $display("unexpected at %0t: controller never ready", $time);
    end
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_byte_en <= m;
    cmd_addr <= x;
    cmd_wdata <= v;
    @(posedge clk);
    cmd_valid <= 1'h0;
    repeat (20) if (rsp_valid !== 1'h1) @(negedge clk);
    if (rsp_valid !== 1'h1) begin
      err_count++;
      $display("unexpected at %0t: no answer", $time);
    end
    rd = rsp_rdata;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report;
    end
  end
  initial begin
    void'($urandom(32'had9b));
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    repeat (30) begin
      a = $urandom;
      w = $urandom;
      ew = $urandom;
      be = $urandom;
      cmd(CMD_MEM_WRITE, 2'h3, a, w);
      cmd(CMD_MEM_WRITE, be, a, ew);
      ew = (ew & bmask(be)) | (w & ~bmask(be));
      be = $urandom;
      cmd(CMD_MEM_READ, be, a, w);
      chk(rd & bmask(be), ew & bmask(be));
    end
    fv = $urandom;
    for (int f = 0; f < 8; f++) cmd(CMD_FLAG_WRITE, 2'($urandom), 13'(f), {15'h7fff, fv[f]});
    for (int f = 0; f < 8; f++) begin
      cmd(CMD_FLAG_READ, 2'($urandom), 13'(f) | 13'h1ff8, 16'h0);
      chk(rd, {16{fv[f]}});
    end
    final_report;
  end
endmodule
